//--- hdl/lbt_loopback_top.sv
/*
  loopback self-test with word monitor, reached over ahb-lite.
  assumes a single ahb-lite master, word transfers only, one 100 MHz clock.
*/
`timescale 1ns/1ps
module lbt_loopback_top #(
  parameter logic       HAS_BC_MON = 1'b1,   // build holds controller and monitor
  parameter logic [4:0] OWN_ADDR   = 5'h00   // terminal address
) (
  input  wire logic        clk,        // system clock
  input  wire logic        rst_n,      // async reset, active low
  input  wire logic        hsel,       // ahb slave select
  input  wire logic [31:0] haddr,      // ahb address
  input  wire logic [1:0]  htrans,     // ahb transfer type
  input  wire logic        hwrite,     // ahb write
  input  wire logic [2:0]  hsize,      // ahb size
  input  wire logic        hready,     // ahb bus ready
  input  wire logic [31:0] hwdata,     // ahb write data
  output logic      [31:0] hrdata,     // ahb read data
  output logic             hreadyout,  // ahb slave ready
  output logic             hresp,      // ahb response
  output logic             mon_run     // monitor capturing
);
  import lbt_pkg::*;
  `include "lbt_regs.svh"

  // --------------------------------------------------------------------------
  // registers and state
  // --------------------------------------------------------------------------
  logic [15:0] main_configuration;      // monitor mode word
  logic [15:0] fourth_configuration;    // test mode field
  logic [15:0] loopback_transmit_word;  // word to send
  logic [15:0] loopback_test_control;   // direction and echo
  logic [11:0] wptr;                    // next monitor location
  logic [11:0] mem_addr;                // host memory window address
  logic [15:0] mem [0:`LBT_MEM_WORDS-1];// shared memory
  logic        soft_rst;                // core reset pulse
  logic        ap_valid;                // data phase pending
  logic        ap_write;                // pending is a write
  logic [4:0]  ap_idx;                  // pending register index
  logic        ap_mem;                  // pending targets memory window
  logic        send;                    // one-cycle send strobe
  logic [7:0]  gap_time;                // half-microsecond counter
  logic [6:0]  half_cnt;                // cycles within a half-microsecond
  logic        seen_word;               // a word was received earlier
  lbt_rx_t     rx_same;                 // echo word
  lbt_rx_t     rx_other;                // far word
  lbt_rx_t     rx_hold;                 // second word waiting for slot
  lbt_wr_t     wr_q;                    // tag write pending
  logic [15:0] tag_same;                // tag of echo
  logic [15:0] tag_other;               // tag of far word
  logic [15:0] tag_hold;                // tag of held word
  logic        test_mode;               // fourth config field set
  logic        mon_mode;                // main config set
  logic        dir_valid;               // test control is a send value
  logic [31:0] rd_mux;                  // read data selected
  logic        wr_fire;                 // host register write now
  logic [15:0] wd;                      // host write data

  // register index decode, used twice in the address phase capture
  function automatic logic [4:0] reg_idx(input logic [31:0] a);
    reg_idx = a[6:2];
  endfunction

  // a test control value that sends a word; direction and echo bits aside
  function automatic logic is_send(input logic [15:0] v);
    is_send = ((v & 16'h7BFF) == (`LBT_SEND_B_TO_A & 16'h7BFF));
  endfunction

  // --------------------------------------------------------------------------
  // ahb address phase capture
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_idx   <= 5'h00;
      ap_mem   <= 1'b0;
    end
    else if (hready)
    begin
      // only nonseq and seq take a phase; hsize assumed word
      ap_valid <= hsel && htrans[1];
      ap_write <= hwrite;
      ap_idx   <= reg_idx(haddr);
      ap_mem   <= (reg_idx(haddr) == `LBT_IDX_MEM_DATA);
    end
  end

  assign wr_fire = ap_valid && ap_write;
  assign wd      = hwdata[15:0];

  // reads take one wait state so that hrdata can come from a flop;
  // writes never wait, and the response is always okay
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // configuration registers; cleared by core reset as well, except mem_addr
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      main_configuration     <= 16'h0000;
      fourth_configuration   <= 16'h0000;
      loopback_transmit_word <= 16'h0000;
      loopback_test_control  <= 16'h0000;
      mem_addr               <= 12'h000;
    end
    else if (soft_rst)
    begin
      main_configuration     <= 16'h0000;
      fourth_configuration   <= 16'h0000;
      loopback_transmit_word <= 16'h0000;
      loopback_test_control  <= 16'h0000;
    end
    else if (wr_fire)
    begin
      case (ap_idx)
        `LBT_IDX_MAIN_CFG:   main_configuration     <= wd;
        `LBT_IDX_FOURTH_CFG: fourth_configuration   <= wd;
        `LBT_IDX_TX_WORD:    loopback_transmit_word <= wd;
        // zero also lands here and stops sending
        `LBT_IDX_TEST_CTRL:  loopback_test_control  <= wd;
        `LBT_IDX_MEM_ADDR:   mem_addr               <= wd[11:0];
        `LBT_IDX_MEM_DATA:   mem_addr               <= mem_addr + 12'h001;
        default:             mem_addr               <= mem_addr;
      endcase
    end
    // a window read steps the address only as its data phase ends
    else if (ap_valid && ap_mem && hready)
      mem_addr <= mem_addr + 12'h001;
  end

  assign test_mode = HAS_BC_MON && (fourth_configuration[2:0] == `LBT_TEST_MODE_VAL);
  assign mon_mode  = HAS_BC_MON && (main_configuration == `LBT_MON_MODE_VAL);
  assign dir_valid = is_send(loopback_test_control);

  // --------------------------------------------------------------------------
  // run control: start and core reset
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mon_run  <= 1'b0;
      soft_rst <= 1'b0;
    end
    else
    begin
      soft_rst <= wr_fire && (ap_idx == `LBT_IDX_RUN_CTRL) && wd[`LBT_RESET_BIT];
      if (soft_rst)
        mon_run <= 1'b0;
      else if (wr_fire && (ap_idx == `LBT_IDX_RUN_CTRL) && (wd == `LBT_START_VAL) && mon_mode)
        mon_run <= 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // send trigger: a test control write with a send value fires one word
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      send <= 1'b0;
    else
      send <= wr_fire && (ap_idx == `LBT_IDX_TEST_CTRL) && test_mode && is_send(wd);
  end

  lbt_tx_chan u_tx (
    .clk      (clk),
    .rst_n    (rst_n),
    .start    (send && dir_valid),
    .from_b   (!loopback_test_control[15]),
    .word     (loopback_transmit_word),
    .rx_same  (rx_same),
    .rx_other (rx_other)
  );

  // --------------------------------------------------------------------------
  // word gap timer in half-microsecond steps
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_cnt  <= 7'h00;
      gap_time  <= 8'h00;
      seen_word <= 1'b0;
    end
    else if (rx_same.valid || rx_hold.valid)
    begin
      half_cnt  <= 7'h00;
      gap_time  <= 8'h00;
      seen_word <= 1'b1;
    end
    else if (half_cnt == 7'(`LBT_HALF_US_CYC - 1))
    begin
      half_cnt <= 7'h00;
      if (gap_time != 8'hFF)
        gap_time <= gap_time + 8'h01;
    end
    else
      half_cnt <= half_cnt + 7'h01;
  end

  lbt_tag_gen u_tag_same (
    .rx        (rx_same),
    .gap_time  (seen_word ? gap_time : 8'h00),
    .back2back (1'b0),
    .own_addr  (OWN_ADDR),
    .tag       (tag_same)
  );

  lbt_tag_gen u_tag_other (
    .rx        (rx_other),
    .gap_time  (8'h00),
    .back2back (1'b0),
    .own_addr  (OWN_ADDR),
    .tag       (tag_other)
  );

  lbt_tag_gen u_tag_hold (
    .rx        (rx_hold),
    .gap_time  (8'h00),
    .back2back (1'b0),
    .own_addr  (OWN_ADDR),
    .tag       (tag_hold)
  );

  // --------------------------------------------------------------------------
  // capture sequencer: one memory word per cycle, data then tag
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_hold <= '0;
      wr_q    <= '0;
      wptr    <= 12'h000;
    end
    else if (soft_rst || !mon_run)
    begin
      rx_hold <= '0;
      wr_q    <= '0;
      wptr    <= mem[`LBT_BASE_LOC][11:0];
    end
    else if (rx_same.valid)
    begin
      if (loopback_test_control[`LBT_ECHO_BIT])
      begin
        rx_hold <= rx_other;
        wr_q    <= '{we: 1'b1, addr: wptr + 12'h001, data: tag_same};
        wptr    <= wptr + 12'h002;
      end
      else
      begin
        rx_hold <= '0;
        wr_q    <= '{we: 1'b1, addr: wptr + 12'h001, data: tag_other};
        wptr    <= wptr + 12'h002;
      end
    end
    else if (rx_hold.valid && !wr_q.we)
    begin
      rx_hold <= '0;
      wr_q    <= '{we: 1'b1, addr: wptr + 12'h001, data: tag_hold};
      wptr    <= wptr + 12'h002;
    end
    else
      wr_q <= '0;
  end

  // --------------------------------------------------------------------------
  // shared memory: host window, data and tag writes
  // --------------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (wr_fire && ap_mem)
      mem[mem_addr] <= wd;
    else if (mon_run && rx_same.valid)
      mem[wptr] <= loopback_test_control[`LBT_ECHO_BIT] ? rx_same.data : rx_other.data;
    else if (wr_q.we)
      mem[wr_q.addr] <= wr_q.data;
    else if (mon_run && rx_hold.valid)
      mem[wptr] <= rx_hold.data;
  end

  // --------------------------------------------------------------------------
  // read mux; unmapped reads zero
  // --------------------------------------------------------------------------
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (ap_idx)
      `LBT_IDX_MAIN_CFG:   rd_mux[15:0] = main_configuration;
      `LBT_IDX_FOURTH_CFG: rd_mux[15:0] = fourth_configuration;
      `LBT_IDX_TX_WORD:    rd_mux[15:0] = loopback_transmit_word;
      `LBT_IDX_TEST_CTRL:  rd_mux[15:0] = loopback_test_control;
      `LBT_IDX_MEM_ADDR:   rd_mux[11:0] = mem_addr;
      `LBT_IDX_MEM_DATA:   rd_mux[15:0] = mem[mem_addr];
      `LBT_IDX_STATUS:     rd_mux[15:0] = {4'h0, wptr};
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // read data loaded in the read wait state, stands once hreadyout is high
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hrdata <= 32'h0000_0000;
    else
      hrdata <= rd_mux;
  end
endmodule // lbt_loopback_top

//--- hdl/lbt_pkg.sv
/*
  types of the loopback word monitor self-test.
  assumes nothing of its surroundings.
*/
package lbt_pkg;
  // one word seen by a receiver channel
  typedef struct packed {
    logic        valid;   // one-cycle strobe
    logic [15:0] data;    // received pattern
    logic        cmd;     // command sync
    logic        err;     // word error
    logic        chan_b;  // received on bus b
  } lbt_rx_t;
  // one pending memory write
  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [15:0] data;
  } lbt_wr_t;
  // sender states
  typedef enum logic [1:0] {
    LBT_IDLE  = 2'b00,
    LBT_SEND  = 2'b01,
    LBT_WAIT  = 2'b10
  } lbt_state_t;
endpackage

//--- hdl/lbt_regs.svh
/*
  register offsets, field positions, values and timing counts of the
  loopback word monitor self-test.
  assumes it is included by its bare name after the package.
*/
`ifndef LBT_REGS_SVH
`define LBT_REGS_SVH

// ----------------------------------------------------------------------------
// register word indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define LBT_IDX_MAIN_CFG      5'h01
`define LBT_IDX_RUN_CTRL      5'h03
`define LBT_IDX_FOURTH_CFG    5'h08
`define LBT_IDX_TX_WORD       5'h0D
`define LBT_IDX_TEST_CTRL     5'h11
`define LBT_IDX_MEM_ADDR      5'h12
`define LBT_IDX_MEM_DATA      5'h13
`define LBT_IDX_STATUS        5'h14
// ----------------------------------------------------------------------------
// values and fields
// ----------------------------------------------------------------------------
`define LBT_TEST_MODE_VAL     3'h2
`define LBT_MON_MODE_VAL      16'h4000
`define LBT_START_VAL         16'h0002
`define LBT_RESET_BIT         0
`define LBT_START_BIT         1
`define LBT_SEND_A_TO_B       16'hBC20
`define LBT_SEND_B_TO_A       16'h3C20
`define LBT_ECHO_BIT          10
`define LBT_BASE_LOC          12'h100
`define LBT_BCAST_ADDR        5'h1F
`define LBT_MEM_WORDS         4096
`define LBT_MEM_AW            12
// ----------------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------------
`define LBT_CLK_MHZ           100
`define LBT_HALF_US_NS        500
`define LBT_HALF_US_CYC       (`LBT_HALF_US_NS * `LBT_CLK_MHZ / 1000)
`define LBT_WORD_NS           20000
`define LBT_WORD_CYC          (`LBT_WORD_NS * `LBT_CLK_MHZ / 1000)
`define LBT_XFER_CYC          40

`endif

//--- hdl/lbt_tag_gen.sv
/*
  builds the tag word for one received word.
  assumes a combinational user; own terminal address given by the caller.
*/
`timescale 1ns/1ps
module lbt_tag_gen (
  input  wire lbt_pkg::lbt_rx_t rx,         // received word
  input  wire logic [7:0]       gap_time,   // half-microseconds since last word
  input  wire logic             back2back,  // no gap before the word
  input  wire logic [4:0]       own_addr,   // terminal address
  output logic      [15:0]      tag         // tag word
);
  import lbt_pkg::*;
  `include "lbt_regs.svh"

  logic [4:0] dest;  // address field of the word
  logic [4:0] sub;   // subaddress field
  assign dest = rx.data[15:11];
  assign sub  = rx.data[9:5];

  // --------------------------------------------------------------------------
  // tag fields
  // --------------------------------------------------------------------------
  always_comb
  begin
    tag[15:8] = gap_time;
    tag[7]    = 1'b1;
    tag[6]    = !((dest == own_addr) || (dest == `LBT_BCAST_ADDR));
    tag[5]    = (dest != `LBT_BCAST_ADDR);
    tag[4]    = rx.err;
    tag[3]    = rx.cmd;
    tag[2]    = rx.chan_b;
    tag[1]    = back2back;
    tag[0]    = !((sub == 5'h1F) || (sub == 5'h00));
  end
endmodule // lbt_tag_gen

//--- hdl/lbt_tx_chan.sv
/*
  models one bus channel driver: takes a word and after a fixed transfer time
  reports it as received on the same bus (echo) and the other bus.
  assumes the analogue loopback bridge delivers the word unchanged.
*/
`timescale 1ns/1ps
module lbt_tx_chan (
  input  wire logic             clk,       // system clock
  input  wire logic             rst_n,     // async reset, active low
  input  wire logic             start,     // one-cycle send strobe
  input  wire logic             from_b,    // send on bus b
  input  wire logic [15:0]      word,      // word to send
  output lbt_pkg::lbt_rx_t      rx_same,   // echo on sending bus
  output lbt_pkg::lbt_rx_t      rx_other   // word on far bus
);
  import lbt_pkg::*;
  `include "lbt_regs.svh"

  logic [5:0]  cnt;   // transfer timer
  logic        busy;  // word on the wire
  logic [15:0] held;  // latched word
  logic        hb;    // latched direction

  // --------------------------------------------------------------------------
  // transfer timer; a new start while busy is dropped
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      busy <= 1'b0;
      cnt  <= 6'h00;
      held <= 16'h0000;
      hb   <= 1'b0;
    end
    else if (start && !busy)
    begin
      busy <= 1'b1;
      cnt  <= 6'(`LBT_XFER_CYC);
      held <= word;
      hb   <= from_b;
    end
    else if (busy)
    begin
      cnt  <= cnt - 6'h01;
      busy <= (cnt != 6'h01);
    end
  end

  // echo and far copy both appear on the last transfer cycle
  always_comb
  begin
    rx_same.valid  = busy && (cnt == 6'h01);
    rx_same.data   = held;
    rx_same.cmd    = 1'b1;
    rx_same.err    = 1'b0;
    rx_same.chan_b = hb;
    rx_other       = rx_same;
    rx_other.chan_b = !hb;
  end
endmodule // lbt_tx_chan

//--- verification/dual_bus_loopback_word_monitor_test_bench.sv
/*
  self-checking bench of the loopback self-test: host setup, three words, readback.
  assumes the host model as bus master and the register header on the include path.
*/
`timescale 1ns/1ps
`include "lbt_regs.svh"
module dual_bus_loopback_word_monitor_test_bench;
  logic        clk;                      // system clock
  logic        rst_n;                    // reset, active low
  wire         hsel, hwrite, rvalid, hreadyout, hresp, mon_run;
  wire  [31:0] haddr, hwdata, hrdata, rdata;
  wire  [1:0]  htrans;
  wire  [2:0]  hsize;
  int          n_errors, n_tests, cyc;   // counters
  logic [31:0] exp_q[$], msk_q[$], e, m; // expected reads and masks
  string       nam_q[$], nm;             // names of expected reads
  logic [15:0] words[3];                 // words sent
  logic [15:0] ctl[3] = '{16'hBC20, 16'h3C20, 16'hB820};
  logic        ch;                       // receiving channel
  logic [31:0] tg;                       // expected tag read
  localparam logic [4:0] mdat = `LBT_IDX_MEM_DATA; // memory window data index
  lbt_loopback_top i_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .mon_run(mon_run));
  lbt_host_model i_host (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .rvalid(rvalid), .rdata(rdata));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // expected tag from the word and channel; time field masked off, words carry command sync
  function automatic logic [15:0] tag_of(input logic [15:0] w, input logic c);
    tag_of    = 16'h0088;
    tag_of[6] = !(w[15:11] == 5'h00 || w[15:11] == 5'h1F);
    tag_of[5] = w[15:11] != 5'h1F;
    tag_of[2] = c;
    tag_of[0] = !(w[9:5] == 5'h00 || w[9:5] == 5'h1F);
  endfunction
  // note an expected read, then perform it
  task automatic rd(input logic [4:0] idx, input logic [31:0] ev, input logic [31:0] mv, input string s);
    exp_q.push_back(ev);
    msk_q.push_back(mv);
    nam_q.push_back(s);
    i_host.xfer(1'b0, idx, 32'h0);
  endtask
  task automatic chk(input string s, input logic ev, input logic sv);
    n_tests++;
    if (sv !== ev)
    begin
      n_errors++;
      $display("[FAIL] %s expected %b seen %b", s, ev, sv);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // watcher: every read result is matched with the oldest note
  always @(posedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      e  = exp_q.pop_front();
      m  = msk_q.pop_front();
      nm = nam_q.pop_front();
      n_tests++;
      if ((rdata & m) !== (e & m))
      begin
        n_errors++;
        $display("[FAIL] %s expected %h seen %h", nm, e & m, rdata & m);
      end
    end
  end
  // hang guard
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    void'($urandom(37125));
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    i_host.xfer(1'b1, `LBT_IDX_FOURTH_CFG, 32'h2);
    i_host.xfer(1'b1, `LBT_IDX_MAIN_CFG, 32'h4000);
    i_host.xfer(1'b1, `LBT_IDX_MEM_ADDR, 32'h100);
    i_host.xfer(1'b1, `LBT_IDX_MEM_DATA, 32'h0);
    rd(`LBT_IDX_MAIN_CFG, 32'h4000, 32'hFFFFFFFF, "main_configuration");
    i_host.xfer(1'b1, `LBT_IDX_RUN_CTRL, 32'h2);
    repeat (3) @(posedge clk);
    chk("mon_run after start", 1'b1, mon_run);
    $display("test setup done");
    // plain, broadcast and mode-command words; last one without echo
    words[0] = 16'($urandom);
    words[1] = {5'h1F, 11'($urandom)};
    words[2] = {5'h00, 1'($urandom), 5'h00, 5'($urandom)};
    for (int i = 0; i < 3; i++)
    begin
      i_host.xfer(1'b1, `LBT_IDX_TX_WORD, {16'h0, words[i]});
      i_host.xfer(1'b1, `LBT_IDX_TEST_CTRL, {16'h0, ctl[i]});
      repeat (2100) @(posedge clk);
    end
    i_host.xfer(1'b1, `LBT_IDX_TEST_CTRL, 32'h0);
    repeat (200) @(posedge clk);
    $display("test transmit done");
    i_host.xfer(1'b1, `LBT_IDX_MEM_ADDR, 32'h0);
    for (int i = 0; i < 3; i++)
    begin
      for (int k = ctl[i][10] ? 0 : 1; k < 2; k++)
      begin
        ch = (k == 1) ~^ ctl[i][15];
        rd(`LBT_IDX_MEM_DATA, {16'h0, words[i]}, 32'hFFFFFFFF, "monitor data");
        tg = {16'h0, tag_of(words[i], ch)};
        rd(mdat, tg, 32'hFFFF00FF, "monitor tag");
      end
    end
    rd(`LBT_IDX_STATUS, 32'd10, 32'hFFFFFFFF, "write pointer");
    $display("test readback done");
    i_host.xfer(1'b1, 5'h1F, 32'hFFFFFFFF);
    rd(5'h1F, 32'h0, 32'hFFFFFFFF, "unmapped");
    i_host.xfer(1'b1, `LBT_IDX_RUN_CTRL, 32'h1);
    repeat (3) @(posedge clk);
    chk("mon_run after soft reset", 1'b0, mon_run);
    rd(`LBT_IDX_MAIN_CFG, 32'h0, 32'hFFFFFFFF, "main_configuration cleared");
    rd(`LBT_IDX_FOURTH_CFG, 32'h0, 32'hFFFFFFFF, "fourth_configuration cleared");
    repeat (5) @(posedge clk);
    $display("test soft reset done");
    wrap_up();
  end
endmodule // dual_bus_loopback_word_monitor_test_bench

//--- verification/lbt_host_model.sv
/*
  host processor model: an ahb-lite master doing single word transfers.
  assumes one slave whose hreadyout is fed back as hready.
*/
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// bus master
// ----------------------------------------------------------------------------
module lbt_host_model (
  input  wire logic        clk,     // system clock
  input  wire logic        hready,  // bus ready
  input  wire logic [31:0] hrdata,  // read data
  output logic             hsel,    // slave select
  output logic      [31:0] haddr,   // address
  output logic      [1:0]  htrans,  // transfer type
  output logic             hwrite,  // write
  output logic      [2:0]  hsize,   // size
  output logic      [31:0] hwdata,  // write data
  output logic             rvalid,  // one-cycle read result strobe
  output logic      [31:0] rdata    // read result
);
  // idle bus at time zero
  initial
  begin
    {hsel, haddr, htrans, hwrite, hsize, hwdata, rvalid, rdata} = '0;
  end
  // one transfer; hwdata is inverted outside its phase so stale data never matches
  task automatic xfer(input logic wr, input logic [4:0] idx, input logic [31:0] wd);
    @(posedge clk);
    hsel   <= 1'b1;
    haddr  <= {25'h0, idx, 2'b00};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    hwdata <= ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge clk); while (hready !== 1'b1);
    // read data is taken at the edge that ends the data phase
    if (!wr)
    begin
      rdata  <= hrdata;
      rvalid <= 1'b1;
      @(posedge clk);
      rvalid <= 1'b0;
    end
  endtask
endmodule // lbt_host_model

//--- verification/lbt_loopback_assertions.sv
/*
  concurrent checks on the ports of the loopback self-test top.
  assumes one ahb-lite master, word transfers and the single clock.
*/
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// port checker
// ----------------------------------------------------------------------------
module lbt_loopback_checker (
  input wire logic        clk,        // system clock
  input wire logic        rst_n,      // async reset, active low
  input wire logic        hsel,       // slave select
  input wire logic [31:0] haddr,      // address
  input wire logic [1:0]  htrans,     // transfer type
  input wire logic        hwrite,     // write
  input wire logic [2:0]  hsize,      // size
  input wire logic        hready,     // bus ready
  input wire logic [31:0] hwdata,     // write data
  input wire logic [31:0] hrdata,     // read data
  input wire logic        hreadyout,  // slave ready
  input wire logic        hresp,      // response
  input wire logic        mon_run     // monitor capturing
);
  logic       wr_p;   // write in its data phase
  logic       rd_p;   // read in its data phase
  logic [4:0] idx_p;  // word index of that phase
  logic       st_d;   // start written one cycle ago
  logic       rs_d;   // soft reset written one cycle ago
  wire        st_now = wr_p && idx_p == 5'h03 && hwdata[1:0] == 2'h2;
  wire        rs_now = wr_p && idx_p == 5'h03 && hwdata[0];
  // anything outside the register map plus the three window registers
  wire        um_p   = !(idx_p inside {5'h01, 5'h03, 5'h08, 5'h0D, 5'h11, 5'h12, 5'h13, 5'h14});
  // track the address phase into its data phase
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_p  <= 1'b0;
      rd_p  <= 1'b0;
      idx_p <= 5'h00;
      st_d  <= 1'b0;
      rs_d  <= 1'b0;
    end
    else
    begin
      wr_p  <= hsel && hready && htrans[1] && hwrite;
      rd_p  <= hsel && hready && htrans[1] && !hwrite;
      idx_p <= haddr[6:2];
      st_d  <= st_now;
      rs_d  <= rs_now;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  hready_high_a: assert property (!hreadyout |=> hreadyout) else $error("slave stalled too long");
  read_wait_a: assert property (hsel && hready && htrans[1] && !hwrite |=> !hreadyout) else $error("no read wait");
  write_nowait_a: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout) else $error("write stalled");
  resp_okay_a: assert property (!hresp) else $error("slave answered with error");
  start_run_a: assert property (st_now |-> ##[1:2] mon_run) else $error("start did not run monitor");
  soft_stop_a: assert property (rs_now |-> ##[1:2] !mon_run) else $error("soft reset left monitor on");
  run_cause_a: assert property ($rose(mon_run) |-> st_d || $past(st_d)) else $error("monitor ran unasked");
  stop_cause_a: assert property ($fell(mon_run) |-> rs_d || $past(rs_d)) else $error("stopped unasked");
  unmapped_zero_a: assert property (rd_p && um_p |=> hrdata == 32'h0) else $error("unmapped read not zero");
  upper_zero_a: assert property (rd_p && !um_p |=> hrdata[31:16] == 16'h0) else $error("upper half set");
  cover property (st_now);
  cover property (rs_now);
  cover property (rd_p && um_p);
endmodule // lbt_loopback_checker

bind lbt_loopback_top lbt_loopback_checker i_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mon_run(mon_run));
